// >>> hw/adsr_defs.svh
`ifndef ADSR_DEFS_SVH
`define ADSR_DEFS_SVH

// ***************************************************
// bus addressing
// ***************************************************
`define ADSR_DEV_ADDR        7'h6c
`define ADSR_SUB_AUTOINC_BIT 7
`define ADSR_IDX_CTRL1       7'h00
`define ADSR_IDX_CTRL2       7'h01
`define ADSR_NUM_STATUS      3'h4

// ***************************************************
// control byte fields
// ***************************************************
`define ADSR_C1_DIAG_EN      6
`define ADSR_C1_OFFSET_EN    5
`define ADSR_C1_UNMUTE_FRONT 2
`define ADSR_C1_UNMUTE_REAR  1
`define ADSR_C2_THR_SEL      7
`define ADSR_C2_WORKING      4
`define ADSR_C2_CUR_DIAG_EN  2
`define ADSR_CTRL_RESET      8'h00

// ***************************************************
// status byte fields
// ***************************************************
`define ADSR_S2_OFFSET_ACT   7
`define ADSR_S2_CUR_ACT      6
`define ADSR_S3_STANDBY      7
`define ADSR_S3_DIAG         6

// ***************************************************
// current thresholds in mA
// ***************************************************
`define ADSR_OPEN_MA_STD     10'd250
`define ADSR_OPEN_MA_LOW     10'd100
`define ADSR_NORM_MA_STD     10'd500
`define ADSR_NORM_MA_LOW     10'd300

// ***************************************************
// turn-on mute timing
// ***************************************************
`define ADSR_CLK_MHZ         20
`define ADSR_MUTE_MIN_US     100000
`define ADSR_MUTE_MAX_US     1000000
`define ADSR_MUTE_MIN_CYC    (`ADSR_MUTE_MIN_US * `ADSR_CLK_MHZ)
`define ADSR_MUTE_MAX_CYC    (`ADSR_MUTE_MAX_US * `ADSR_CLK_MHZ)

`endif

// >>> hw/adsr_pkg.sv
package adsr_pkg;

  // bus engine states
  typedef enum logic [6:0] {
    ADSR_S_IDLE = 7'b0000001,
    ADSR_S_ADDR = 7'b0000010,
    ADSR_S_ACK  = 7'b0000100,
    ADSR_S_RX   = 7'b0001000,
    ADSR_S_TX   = 7'b0010000,
    ADSR_S_MACK = 7'b0100000,
    ADSR_S_WAIT = 7'b1000000
  } adsr_bus_st_t;

  // turn-on mute states
  typedef enum logic [3:0] {
    ADSR_M_OFF  = 4'b0001,
    ADSR_M_DIAG = 4'b0010,
    ADSR_M_MUTE = 4'b0100,
    ADSR_M_RUN  = 4'b1000
  } adsr_mute_st_t;

endpackage

// >>> hw/adsr_chan_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "adsr_defs.svh"

module adsr_chan_status
  import adsr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic       thr_sel_in,
  input  wire logic [9:0] peak_ma_in,
  input  wire logic       permanent_in,
  input  wire logic       short_load_in,
  input  wire logic       open_load_in,
  input  wire logic       offset_mode_in,
  input  wire logic       offset_in,
  input  wire logic       short_vcc_in,
  input  wire logic       short_gnd_in,
  output logic      [5:0] status_out
);

  logic [9:0] open_lim;
  logic [9:0] norm_lim;
  logic       cur_open_r;

  // ***************************************************
  // current judgement
  // ***************************************************
  // threshold set picked by the control bit
  assign open_lim = thr_sel_in ? `ADSR_OPEN_MA_LOW : `ADSR_OPEN_MA_STD;
  assign norm_lim = thr_sel_in ? `ADSR_NORM_MA_LOW : `ADSR_NORM_MA_STD;

  // between the limits the last verdict holds
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cur_open_r <= 1'b0;
    end else if (peak_ma_in < open_lim) begin
      cur_open_r <= 1'b1;
    end else if (peak_ma_in > norm_lim) begin
      cur_open_r <= 1'b0;
    end
  end

  // ***************************************************
  // status bits 5..0
  // ***************************************************
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      status_out <= 6'h00;
    end else begin
      status_out[5] <= cur_open_r;
      status_out[4] <= permanent_in;
      status_out[3] <= short_load_in;
      status_out[2] <= offset_mode_in ? offset_in : open_load_in;
      status_out[1] <= short_vcc_in;
      status_out[0] <= short_gnd_in;
    end
  end

endmodule
`default_nettype wire

// >>> hw/adsr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "adsr_defs.svh"


module adsr_top
  import adsr_pkg::*;
#(
  parameter int unsigned MUTE_MIN_CYC = `ADSR_MUTE_MIN_CYC,
  parameter int unsigned MUTE_MAX_CYC = `ADSR_MUTE_MAX_CYC,
  parameter int unsigned CNT_W        = 25
)(
  input  wire logic            clk_sys_in,
  input  wire logic            srst_in,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe_out,
  input  wire logic      [7:0] first_status_byte_in,
  input  wire logic [2:0][9:0] peak_ma_in,
  input  wire logic      [2:0] big_load_volt_in,
  input  wire logic      [2:0] offset_in,
  input  wire logic      [2:0] short_vcc_in,
  input  wire logic      [2:0] short_gnd_in,
  input  wire logic            diag_cycle_done_in,
  input  wire logic            ripple_ready_in,
  output logic           [7:0] first_control_byte_out,
  output logic           [7:0] second_control_byte_out,
  output logic                 front_audio_on_out,
  output logic                 rear_audio_on_out,
  output logic                 auto_mute_out,
  output logic                 permanent_diag_out
);

  // ***************************************************
  // declarations
  // ***************************************************
  adsr_bus_st_t     state_r;
  adsr_mute_st_t    mute_st_r;
  logic             scl_q_r;
  logic             sda_q_r;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_cond;
  logic             stop_cond;
  logic       [7:0] shift_r;
  logic       [7:0] rx_byte;
  logic       [2:0] bit_cnt_r;
  logic             rw_r;
  logic             sub_seen_r;
  logic             auto_inc_r;
  logic       [6:0] ptr_r;
  logic             ack_drv_r;
  logic             mack_seen_r;
  logic             more_r;
  logic       [7:0] ctrl1_r;
  logic       [7:0] ctrl2_r;
  logic       [7:0] ctrl2_nxt;
  logic             wr_strobe;
  logic [2:0][5:0]  chan_bits;
  logic       [7:0] ch2_byte;
  logic       [7:0] ch3_byte;
  logic       [7:0] ch4_byte;
  logic       [7:0] tx_byte;
  logic             perm_r;
  logic [CNT_W-1:0] mute_cnt_r;
  logic             power_on_evt;

  // ***************************************************
  // bus line sampling and conditions
  // ***************************************************
  // previous line levels for edge detection
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  assign scl_rise   = scl_in & ~scl_q_r;
  assign scl_fall   = ~scl_in & scl_q_r;
  assign start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_cond  = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign rx_byte    = {shift_r[6:0], sda_in};

  // ***************************************************
  // status byte assembly
  // ***************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      adsr_chan_status u_chan (
        .clk_sys_in     (clk_sys_in),
        .srst_in        (srst_in),
        .thr_sel_in     (ctrl2_r[`ADSR_C2_THR_SEL]),
        .peak_ma_in     (peak_ma_in[gi]),
        .permanent_in   (perm_r),
        .short_load_in  (~big_load_volt_in[gi]),
        .open_load_in   (big_load_volt_in[gi]),
        .offset_mode_in (ctrl1_r[`ADSR_C1_OFFSET_EN]),
        .offset_in      (offset_in[gi]),
        .short_vcc_in   (short_vcc_in[gi]),
        .short_gnd_in   (short_gnd_in[gi]),
        .status_out     (chan_bits[gi])
      );
    end
  endgenerate

  assign ch2_byte = {ctrl1_r[`ADSR_C1_OFFSET_EN],
                     ctrl2_r[`ADSR_C2_CUR_DIAG_EN], chan_bits[0]};
  assign ch3_byte = {ctrl2_r[`ADSR_C2_WORKING],
                     ctrl1_r[`ADSR_C1_DIAG_EN], chan_bits[1]};
  assign ch4_byte = {2'b00, chan_bits[2]};

  always_comb begin
    unique case (ptr_r[1:0])
      2'd0:    tx_byte = first_status_byte_in;
      2'd1:    tx_byte = ch2_byte;
      2'd2:    tx_byte = ch3_byte;
      default: tx_byte = ch4_byte;
    endcase
  end

  // ***************************************************
  // bus engine
  // ***************************************************
  // byte completed in a write phase after the sub-address
  assign wr_strobe = (state_r == ADSR_S_RX) && scl_rise &&
                     (bit_cnt_r == 3'd7) && sub_seen_r;

  // serial slave sequencing
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_r     <= ADSR_S_IDLE;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 3'd0;
      rw_r        <= 1'b0;
      sub_seen_r  <= 1'b0;
      auto_inc_r  <= 1'b0;
      ptr_r       <= 7'h00;
      ack_drv_r   <= 1'b0;
      mack_seen_r <= 1'b0;
      more_r      <= 1'b0;
      sda_oe_out  <= 1'b0;
    end else if (start_cond) begin
      state_r     <= ADSR_S_ADDR;
      bit_cnt_r   <= 3'd0;
      sub_seen_r  <= 1'b0;
      ack_drv_r   <= 1'b0;
      sda_oe_out  <= 1'b0;
    end else if (stop_cond) begin
      state_r     <= ADSR_S_IDLE;
      sda_oe_out  <= 1'b0;
    end else begin
      unique case (state_r)
        ADSR_S_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        ADSR_S_ADDR: begin
          if (scl_rise) begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
              if (rx_byte[7:1] == `ADSR_DEV_ADDR) begin
                rw_r    <= rx_byte[0];
                ptr_r   <= 7'h00;
                state_r <= ADSR_S_ACK;
              end else begin
                state_r <= ADSR_S_WAIT;
              end
            end
          end
        end
        ADSR_S_ACK: begin
          if (scl_fall && !ack_drv_r) begin
            ack_drv_r  <= 1'b1;
            sda_oe_out <= 1'b1;
          end else if (scl_fall) begin
            ack_drv_r <= 1'b0;
            bit_cnt_r <= 3'd0;
            if (rw_r) begin
              shift_r    <= tx_byte;
              sda_oe_out <= ~tx_byte[7];
              state_r    <= ADSR_S_TX;
            end else begin
              sda_oe_out <= 1'b0;
              state_r    <= ADSR_S_RX;
            end
          end
        end
        ADSR_S_RX: begin
          if (scl_rise) begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
              state_r <= ADSR_S_ACK;
              if (!sub_seen_r) begin
                sub_seen_r <= 1'b1;
                auto_inc_r <= rx_byte[`ADSR_SUB_AUTOINC_BIT];
                ptr_r      <= rx_byte[6:0];
              end else if (auto_inc_r && ptr_r != 7'h7f) begin
                ptr_r <= ptr_r + 7'h01;
              end
            end
          end
        end
        ADSR_S_TX: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
              sda_oe_out  <= 1'b0;
              mack_seen_r <= 1'b0;
              state_r     <= ADSR_S_MACK;
            end else begin
              shift_r    <= {shift_r[6:0], 1'b0};
              sda_oe_out <= ~shift_r[6];
            end
          end
        end
        ADSR_S_MACK: begin
          if (scl_rise) begin
            mack_seen_r <= 1'b1;
            more_r      <= ~sda_in;
            if (!sda_in && ptr_r[1:0] != 2'd3) begin
              ptr_r <= ptr_r + 7'h01;
            end
          end else if (scl_fall && mack_seen_r) begin
            bit_cnt_r <= 3'd0;
            if (more_r) begin
              shift_r    <= tx_byte;
              sda_oe_out <= ~tx_byte[7];
              state_r    <= ADSR_S_TX;
            end else begin
              sda_oe_out <= 1'b0;
              state_r    <= ADSR_S_WAIT;
            end
          end
        end
        ADSR_S_WAIT: begin
          sda_oe_out <= 1'b0;
        end
        default: begin
          state_r    <= ADSR_S_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data line only ever pulls low
  always_ff @(posedge clk_sys_in) begin
    sda_out <= 1'b0;
  end

  // ***************************************************
  // control bytes
  // ***************************************************
  // only control bytes take writes
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl1_r <= `ADSR_CTRL_RESET;
    end else if (wr_strobe && ptr_r == `ADSR_IDX_CTRL1) begin
      ctrl1_r <= rx_byte;
    end
  end

  assign ctrl2_nxt = (wr_strobe && ptr_r == `ADSR_IDX_CTRL2) ? rx_byte
                                                             : ctrl2_r;

  // second control byte holds standby and threshold select
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl2_r <= `ADSR_CTRL_RESET;
    end else begin
      ctrl2_r <= ctrl2_nxt;
    end
  end

  // control bytes mirrored out
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      first_control_byte_out  <= `ADSR_CTRL_RESET;
      second_control_byte_out <= `ADSR_CTRL_RESET;
    end else begin
      first_control_byte_out  <= ctrl1_r;
      second_control_byte_out <= ctrl2_r;
    end
  end

  // ***************************************************
  // turn-on mute sequencing
  // ***************************************************
  // standby released by a write: power-on command
  assign power_on_evt = ctrl2_nxt[`ADSR_C2_WORKING] &
                        ~ctrl2_r[`ADSR_C2_WORKING];

  // mute state and duration count
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      mute_st_r  <= ADSR_M_OFF;
      mute_cnt_r <= '0;
      perm_r     <= 1'b0;
    end else if (!ctrl2_r[`ADSR_C2_WORKING]) begin
      mute_st_r  <= ADSR_M_OFF;
      mute_cnt_r <= '0;
      perm_r     <= 1'b0;
    end else begin
      unique case (mute_st_r)
        ADSR_M_OFF: begin
          mute_cnt_r <= '0;
          if (power_on_evt || ctrl2_r[`ADSR_C2_WORKING]) begin
            mute_st_r <= ctrl1_r[`ADSR_C1_DIAG_EN] ? ADSR_M_DIAG
                                                   : ADSR_M_MUTE;
          end
        end
        ADSR_M_DIAG: begin
          if (diag_cycle_done_in) begin
            perm_r    <= 1'b1;
            mute_st_r <= ADSR_M_MUTE;
          end
        end
        ADSR_M_MUTE: begin
          mute_cnt_r <= mute_cnt_r + 1'b1;
          if (mute_cnt_r >= CNT_W'(MUTE_MAX_CYC - 1) ||
              (ripple_ready_in &&
               mute_cnt_r >= CNT_W'(MUTE_MIN_CYC - 1))) begin
            mute_st_r <= ADSR_M_RUN;
          end
        end
        ADSR_M_RUN: begin
          mute_cnt_r <= '0;
        end
      endcase
    end
  end

  // ***************************************************
  // audio enables
  // ***************************************************
  // turn-on mute overrides unmute
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      auto_mute_out      <= 1'b1;
      front_audio_on_out <= 1'b0;
      rear_audio_on_out  <= 1'b0;
      permanent_diag_out <= 1'b0;
    end else begin
      auto_mute_out      <= (mute_st_r != ADSR_M_RUN);
      front_audio_on_out <= (mute_st_r == ADSR_M_RUN) &&
                            ctrl1_r[`ADSR_C1_UNMUTE_FRONT];
      rear_audio_on_out  <= (mute_st_r == ADSR_M_RUN) &&
                            ctrl1_r[`ADSR_C1_UNMUTE_REAR];
      permanent_diag_out <= perm_r;
    end
  end

endmodule
`default_nettype wire

// >>> tb/adsr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adsr_monitor #(
  parameter int unsigned MUTE_MIN_CYC = 20,
  parameter int unsigned MUTE_MAX_CYC = 200
)(
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_oe_out,
  input  wire logic [7:0] first_control_byte_out,
  input  wire logic [7:0] second_control_byte_out,
  input  wire logic       front_audio_on_out,
  input  wire logic       rear_audio_on_out,
  input  wire logic       auto_mute_out,
  input  wire logic       permanent_diag_out
);
  // ************************************************
  // mute timing and bus output checks
  // ************************************************
  logic [31:0] mute_cnt_r;
  wire  logic  work = second_control_byte_out[4];
  // mute length once any diag wait is over
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !auto_mute_out || !work) begin
      mute_cnt_r <= 32'h0;
    end else if (!first_control_byte_out[6] || permanent_diag_out) begin
      mute_cnt_r <= mute_cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  sequence work_rise_s;
    $rose(work);
  endsequence
  sequence muted_s;
    auto_mute_out[*3];
  endsequence
  sequence mute_end_s;
    $fell(auto_mute_out) && work;
  endsequence
  mute_blocks_a: assert property (muted_s |->
    !front_audio_on_out && !rear_audio_on_out) else $error("audio in mute");
  front_rise_a: assert property ($rose(front_audio_on_out) |->
    first_control_byte_out[2] && !auto_mute_out) else $error("front early");
  rear_rise_a: assert property ($rose(rear_audio_on_out) |->
    first_control_byte_out[1] && !auto_mute_out) else $error("rear early");
  standby_mute_a: assert property ((!work)[*3] |-> auto_mute_out)
    else $error("standby not muted");
  startup_mute_a: assert property (work_rise_s |-> muted_s)
    else $error("power-on not muted");
  mute_min_a: assert property (mute_end_s |->
    mute_cnt_r >= MUTE_MIN_CYC - 3) else $error("mute too short");
  mute_max_a: assert property (mute_cnt_r <= MUTE_MAX_CYC + 3)
    else $error("mute too long");
  diag_first_a: assert property ($rose(permanent_diag_out) |-> muted_s)
    else $error("mute gone before diag end");
  sda_stable_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
endmodule
bind adsr_top adsr_monitor #(
  .MUTE_MIN_CYC(MUTE_MIN_CYC), .MUTE_MAX_CYC(MUTE_MAX_CYC)
) i_mon (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl_in),
  .sda_oe_out(sda_oe_out), .first_control_byte_out(first_control_byte_out),
  .second_control_byte_out(second_control_byte_out),
  .front_audio_on_out(front_audio_on_out),
  .rear_audio_on_out(rear_audio_on_out), .auto_mute_out(auto_mute_out),
  .permanent_diag_out(permanent_diag_out));
`default_nettype wire

// >>> tb/adsr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module adsr_host_model (
  input  wire logic clk_sys_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_out
);
  // ************************************************
  // serial bus master
  // ************************************************
  // idle bus, both lines released
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // one bus phase, four clocks
  task automatic ph();
    repeat (4) @(negedge clk_sys_in);
  endtask
  // data falls with clock high
  task automatic start();
    sda_out = 1'b1;
    ph();
    scl_out = 1'b1;
    ph();
    sda_out = 1'b0;
    ph();
    scl_out = 1'b0;
    ph();
  endtask
  // data rises with clock high
  task automatic stop();
    sda_out = 1'b0;
    ph();
    scl_out = 1'b1;
    ph();
    sda_out = 1'b1;
    ph();
  endtask
  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] d, input logic l,
                      output logic [7:0] r, output logic a);
    logic [8:0] s;
    logic [8:0] q;
    s = {d, l};
    for (int i = 8; i >= 0; i--) begin
      sda_out = s[i];
      ph();
      scl_out = 1'b1;
      ph();
      q[i] = sda_in;
      scl_out = 1'b0;
      ph();
    end
    r = q[8:1];
    a = q[0];
  endtask
endmodule
`default_nettype wire

// >>> tb/adsr_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adsr_defs.svh"
module adsr_top_tb;
  // ************************************************
  // bench for the status readout
  // ************************************************
  localparam int unsigned MIN_C = 20;
  localparam int unsigned MAX_C = 200;
  localparam logic [7:0]  AD = {`ADSR_DEV_ADDR, 1'b0};
  logic            clk_sys_in, srst_in, scl, host_sda, sda_out, sda_oe_out;
  logic [7:0]      st1, c1, c2, c1_o, c2_o;
  logic [2:0][9:0] peak;
  logic [2:0]      big, off, vcc, gnd, prev;
  logic            done, rdy, fr, rr, am, pd, pd_e;
  wire  logic      sda_w = sda_oe_out ? 1'b0 : host_sda;
  int              num_errors, total_checks, cyc;
  logic [9:0]      tbl [4] = '{10'd50, 10'd200, 10'd400, 10'd700};
  adsr_top #(.MUTE_MIN_CYC(MIN_C), .MUTE_MAX_CYC(MAX_C)) i_dut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .first_status_byte_in(st1), .peak_ma_in(peak), .big_load_volt_in(big),
    .offset_in(off), .short_vcc_in(vcc), .short_gnd_in(gnd),
    .diag_cycle_done_in(done), .ripple_ready_in(rdy),
    .first_control_byte_out(c1_o), .second_control_byte_out(c2_o),
    .front_audio_on_out(fr), .rear_audio_on_out(rr), .auto_mute_out(am),
    .permanent_diag_out(pd));
  adsr_host_model i_host (.clk_sys_in(clk_sys_in), .sda_in(sda_w),
    .scl_out(scl), .sda_out(host_sda));
  // 20 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic upd();
    for (int i = 0; i < 3; i++) begin
      if (peak[i] < (c2[7] ? 10'd100 : 10'd250)) prev[i] = 1'b1;
      else if (peak[i] > (c2[7] ? 10'd300 : 10'd500)) prev[i] = 1'b0;
    end
  endtask
  function automatic logic [5:0] ch(int i);
    ch = {prev[i], pd_e, ~big[i], c1[5] ? off[i] : big[i], vcc[i], gnd[i]};
  endfunction
  // address, auto-increment index, two data bytes
  task automatic wr(input logic [7:0] a0, input logic [6:0] idx,
                    input logic [7:0] d1, input logic [7:0] d2);
    logic [7:0] q [4];
    logic [7:0] r;
    logic       a;
    logic       na;
    q = '{a0, {1'b1, idx}, d1, d2};
    na = (a0 != AD);
    i_host.start();
    for (int k = 0; k < 4; k++) begin
      i_host.xfer(q[k], 1'b1, r, a);
      chk({7'h0, a}, {7'h0, na});
    end
    i_host.stop();
    if (!na && idx == 7'h00) begin
      c1 = d1;
      c2 = d2;
      pd_e = pd_e & d2[4];
    end
    repeat (3) @(negedge clk_sys_in);
    chk(c1_o, c1);
    chk(c2_o, c2);
    upd();
  endtask
  task automatic rd();
    logic [7:0] e [4];
    logic [7:0] r;
    logic [7:0] m;
    logic       a;
    e = '{st1, {c1[5], c2[2], ch(0)}, {c2[4], c1[6], ch(1)}, {2'h0, ch(2)}};
    m = c2[2] ? 8'hff : 8'hdf;
    i_host.start();
    i_host.xfer({`ADSR_DEV_ADDR, 1'b1}, 1'b1, r, a);
    chk({7'h0, a}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      i_host.xfer(8'hff, k == 3, r, a);
      chk(k == 0 ? r : r & m, k == 0 ? e[0] : e[k] & m);
    end
    i_host.stop();
  endtask
  // bounded wait for the turn-on mute to end
  task automatic wt();
    for (int n = 0; n < MAX_C + 50 && am !== 1'b0; n++) begin
      @(negedge clk_sys_in);
    end
    chk({7'h0, am}, 8'h00);
  endtask
  // main sequence
  initial begin
    srst_in = 1'b1;
    {st1, c1, c2, peak, big, off, vcc, gnd, prev} = '0;
    {done, rdy, pd_e} = 3'h0;
    void'($urandom(32'h2728bcf1));
    repeat (16) @(negedge clk_sys_in);
    srst_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk({3'h0, sda_out, am, fr, rr, pd}, 8'h08);
    upd();
    rd();
    wr({7'h6d, 1'b0}, 7'h00, 8'hff, 8'hff);
    wr(AD, 7'h05, 8'hff, 8'hff);
    rd();
    for (int n = 0; n < 12; n++) begin
      wr(AD, 7'h00, 8'($urandom) & 8'hbf, 8'($urandom));
      st1 = 8'($urandom);
      {big, off, vcc, gnd} = 12'($urandom);
      rdy = 1'($urandom);
      for (int i = 0; i < 3; i++) peak[i] = tbl[2'($urandom)];
      upd();
      repeat (2) rd();
    end
    rdy = 1'b0;
    wr(AD, 7'h00, 8'h06, 8'h04);
    wr(AD, 7'h00, 8'h46, 8'h14);
    repeat (50) @(negedge clk_sys_in);
    chk({6'h0, am, fr}, 8'h02);
    done = 1'b1;
    @(negedge clk_sys_in);
    done = 1'b0;
    pd_e = 1'b1;
    rdy = 1'b1;
    wt();
    repeat (3) @(negedge clk_sys_in);
    chk({5'h0, pd, fr, rr}, 8'h07);
    rd();
    rdy = 1'b0;
    wr(AD, 7'h00, 8'h06, 8'h04);
    wr(AD, 7'h00, 8'h06, 8'h14);
    repeat (MIN_C) @(negedge clk_sys_in);
    chk({7'h0, am}, 8'h01);
    wt();
    wrap_up();
  end
endmodule
`default_nettype wire
